// file: timer_mode_control_regs_test.sv
// self-checking bench for the timer mode and control registers
`timescale 1ns/10ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin failures++; \
   $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module timer_mode_control_regs_test;
   import tmcr_pkg::*;
   logic        aclk = 1'b0, aresetn = 1'b0, clk_en = 1'b1, debug_halt = 1'b0;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, a_pwm_raw = 1'b0, a_trigger_raw = 1'b0;
   logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, v;
   logic [3:0]  s_axi_wstrb = 4'hF;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic        b_count_enable, b_capture_enable, b_capture_submode, a_pwm_out, a_adc_trigger;
   logic [1:0]  s_axi_bresp, s_axi_rresp, b_timer_mode_field, b_edge_select;
   logic [33:0] exp_q[$], e;
   logic [1:0]  bexp_q[$], eb;
   int          failures = 0, checked = 0, cycles = 0, i;
   integer      seed = 32'h8CED;
   tmcr_regs dut (.aclk, .aresetn, .clk_en, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .debug_halt, .a_pwm_raw, .a_trigger_raw, .b_count_enable,
      .b_capture_enable, .b_capture_submode, .b_timer_mode_field, .b_edge_select, .a_pwm_out,
      .a_adc_trigger);
   initial begin
      forever #4 aclk = ~aclk;
   end
   task report_and_stop;
      $display("failures %0d checked %0d", failures, checked);
      if (failures == 0 && checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   always @(posedge aclk) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         report_and_stop;
      end
   end
   // readies are sampled mid-cycle so the edge decision never races the design
   task automatic wr(input logic [11:0] a, input logic [31:0] d,
                     input logic [1:0] rs = TMCR_RESP_OKAY);
      logic [2:0] t;
      t = 3'h0;
      bexp_q.push_back(rs);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!t[0]) begin
         @(negedge aclk);
         t = {s_axi_awready, s_axi_wready, s_axi_bvalid};
         @(posedge aclk);
         if (t[2]) s_axi_awvalid <= 1'b0;
         if (t[1]) s_axi_wvalid <= 1'b0;
      end
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [33:0] x);
      logic [1:0] t;
      t = 2'h0;
      exp_q.push_back(x);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      while (!t[0]) begin
         @(negedge aclk);
         t = {s_axi_arready, s_axi_rvalid};
         @(posedge aclk);
         if (t[1]) s_axi_arvalid <= 1'b0;
      end
      s_axi_rready <= 1'b0;
   endtask
   task automatic settle(input int n);
      repeat (n) @(negedge aclk);
   endtask
   always @(negedge aclk) begin
      if (s_axi_rvalid && s_axi_rready) begin
         e = exp_q.pop_front();
         `CHK({s_axi_rresp, s_axi_rdata}, e)
      end
      if (s_axi_bvalid && s_axi_bready) begin
         eb = bexp_q.pop_front();
         `CHK(s_axi_bresp, eb)
      end
   end
   initial begin
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      rd(TMCR_OFS_CTL, 34'h0);
      wr(TMCR_OFS_CTL, 32'hFFFF_FFFF);
      rd(TMCR_OFS_CTL, {2'h0, TMCR_CTL_WMASK});
      rd(12'h014, {TMCR_RESP_SLVERR, 32'h0});
      wr(12'h014, 32'h1, TMCR_RESP_SLVERR);
      wr(TMCR_OFS_STAT, 32'hFFFF_FFFF);
      rd(TMCR_OFS_CTL, {2'h0, TMCR_CTL_WMASK});
      wr(TMCR_OFS_CFG, 32'h4);
      for (i = 0; i < 8; i++) begin
         v = $random(seed);
         wr(TMCR_OFS_BMODE, {v[31:4], 1'b0, i[2:0]});
         settle(3);
         `CHK({b_capture_submode, b_timer_mode_field}, i[2:0])
         `CHK({b_count_enable, b_capture_enable}, {i[1:0] inside {1, 2}, i[1:0] == 2'h3})
      end
      rd(TMCR_OFS_BMODE, 34'h7);
      wr(TMCR_OFS_AMODE, 32'h1);
      wr(TMCR_OFS_BMODE, 32'h6);
      wr(TMCR_OFS_CTL, 32'h100);
      for (i = 0; i < 8; i++) begin
         wr(TMCR_OFS_CFG, i[31:0]);
         settle(3);
         v[3:0] = {!(i inside {2, 3}), i[2], i[2] ? 2'h2 : 2'h1};
         `CHK({b_count_enable, b_capture_submode, b_timer_mode_field}, v[3:0])
      end
      for (i = 0; i < 4; i++) begin
         wr(TMCR_OFS_CTL, {20'h0, i[1:0], 10'h100});
         settle(3);
         `CHK(b_edge_select, i[1:0])
      end
      // halt goes through a synchroniser, so allow it extra cycles
      for (i = 0; i < 4; i++) begin
         @(posedge aclk);
         debug_halt <= i[1];
         wr(TMCR_OFS_CTL, {22'h0, i[0], 9'h100});
         settle(6);
         `CHK(b_count_enable, !(i[0] && i[1]))
      end
      // pwm setup: alternate set, submode clear, periodic mode
      wr(TMCR_OFS_CTL, 32'h100);
      wr(TMCR_OFS_BMODE, 32'hA);
      settle(3);
      v[4:0] = {b_count_enable, b_capture_enable, b_capture_submode, b_timer_mode_field};
      `CHK(v[4:0], 5'h12)
      wr(TMCR_OFS_BMODE, 32'h8);
      settle(3);
      `CHK({b_count_enable, b_capture_enable}, 2'h0)
      wr(TMCR_OFS_CTL, 32'h0);
      settle(3);
      `CHK(b_count_enable, 1'b0)
      for (i = 0; i < 8; i++) begin
         v = $random(seed);
         wr(TMCR_OFS_CTL, {25'h0, i[1:0], 5'h0});
         @(posedge aclk);
         a_pwm_raw <= v[0];
         a_trigger_raw <= v[1];
         settle(2);
         `CHK({a_pwm_out, a_adc_trigger}, {v[0] ^ i[1], v[1] & i[0]})
      end
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      rd(TMCR_OFS_CTL, 34'h0);
      settle(4);
      report_and_stop;
   end
endmodule

// file: tmcr_pkg.sv
// constants for the timer mode and control register block
package tmcr_pkg;
   localparam logic [11:0] TMCR_OFS_CFG   = 12'h000;
   localparam logic [11:0] TMCR_OFS_AMODE = 12'h004;
   localparam logic [11:0] TMCR_OFS_BMODE = 12'h008;
   localparam logic [11:0] TMCR_OFS_CTL   = 12'h00C;
   localparam logic [11:0] TMCR_OFS_STAT  = 12'h010;

   localparam int TMCR_MODE_FIELD_LSB = 0;
   localparam int TMCR_MODE_CMR_BIT   = 2;
   localparam int TMCR_MODE_AMS_BIT   = 3;
   localparam int TMCR_CTL_A_EN_BIT   = 0;
   localparam int TMCR_CTL_A_OTE_BIT  = 5;
   localparam int TMCR_CTL_A_INV_BIT  = 6;
   localparam int TMCR_CTL_B_EN_BIT   = 8;
   localparam int TMCR_CTL_B_STL_BIT  = 9;
   localparam int TMCR_CTL_B_EVT_LSB  = 10;

   localparam logic [31:0] TMCR_CFG_WMASK  = 32'h0000_0007;
   localparam logic [31:0] TMCR_MODE_WMASK = 32'h0000_000F;
   localparam logic [31:0] TMCR_CTL_WMASK  = 32'h0000_0F61;
   localparam logic [31:0] TMCR_RESET_VAL  = 32'h0000_0000;

   localparam logic [1:0] TMCR_RESP_OKAY   = 2'h0;
   localparam logic [1:0] TMCR_RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      TMCR_TM_RSVD     = 2'h0,
      TMCR_TM_ONESHOT  = 2'h1,
      TMCR_TM_PERIODIC = 2'h2,
      TMCR_TM_CAPTURE  = 2'h3
   } tmcr_tmode_t;

   typedef enum logic [1:0] {
      TMCR_EDGE_RISE = 2'h0,
      TMCR_EDGE_FALL = 2'h1,
      TMCR_EDGE_RSVD = 2'h2,
      TMCR_EDGE_BOTH = 2'h3
   } tmcr_edge_t;

   typedef enum logic [2:0] {
      TMCR_CFG_32TIMER = 3'h0,
      TMCR_CFG_32RTC   = 3'h1,
      TMCR_CFG_RSVD2   = 3'h2,
      TMCR_CFG_RSVD3   = 3'h3,
      TMCR_CFG_16A     = 3'h4,
      TMCR_CFG_16B     = 3'h5,
      TMCR_CFG_16C     = 3'h6,
      TMCR_CFG_16D     = 3'h7
   } tmcr_cfg_t;

   typedef struct packed {
      logic [31:0] cfg;
      logic [31:0] amode;
      logic [31:0] bmode;
      logic [31:0] ctl;
      logic        aw_got;
      logic [11:0] aw_addr;
      logic        w_got;
      logic [31:0] w_data;
      logic [3:0]  w_strb;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
      logic        b_count_en;
      logic        b_capture_en;
      logic        b_edge_time;
      logic [1:0]  b_mode_eff;
      logic [1:0]  b_edge_sel;
      logic        a_pwm_out;
      logic        a_adc_trig;
   } tmcr_state_t;
endpackage

// file: tmcr_regs.sv
// timer mode and control registers with AXI4-Lite slave
`timescale 1ns/10ps

// Contract
// R1: b capture submode: 0 count, 1 time
// R2: mode field: reserved, one-shot, periodic, capture
// R3: split config uses TimerB mode field
// R4: 32-bit config takes mode from TimerA
// R5: edge select bits 11:10 pick capture edge
// R6: bit 9 freezes TimerB during debug halt; code gates only count enable, capture enable stays on
// R7: freeze ignored when processor runs normally
// R8: bit 8 enables TimerB count or capture
// R9: bit 6 inverts TimerA PWM output
// R10: bit 5 gates TimerA ADC trigger
// R11: software sets PWM via alternate, submode, mode
// R12: config decodes 32 timer, RTC, split
// R13: control bits 12 and 7 read zero
module tmcr_regs
   import tmcr_pkg::*;
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        clk_en,
   input  wire logic [11:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [11:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        debug_halt,
   input  wire logic        a_pwm_raw,
   input  wire logic        a_trigger_raw,
   output logic             b_count_enable,
   output logic             b_capture_enable,
   output logic             b_capture_submode,
   output logic [1:0]       b_timer_mode_field,
   output logic [1:0]       b_edge_select,
   output logic             a_pwm_out,
   output logic             a_adc_trigger
);
   import tmcr_pkg::*;

   tmcr_state_t s_q;
   tmcr_state_t s_d;
   logic [2:0]  halt_sync_q;
   logic        halt_q;

   // debug halt arrives from the processor domain; three stages, accept on agreement
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         halt_sync_q <= 3'h0;
         halt_q      <= 1'b0;
      end else if (clk_en) begin
         halt_sync_q <= {halt_sync_q[1:0], debug_halt};
         if (halt_sync_q[1] == halt_sync_q[2]) begin
            halt_q <= halt_sync_q[2];
         end
      end
   end

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                         input logic [3:0] be, input logic [31:0] msk);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[i*8 +: 8] = wd[i*8 +: 8];
         end
      end
      return r & msk; // R13
   endfunction

   logic        split;
   logic [31:0] mode_sel;
   logic        b_stall;
   logic        b_en;

   always_comb begin
      s_d = s_q;
      // address and data are latched separately so either order works
      if (s_axi_awvalid && !s_q.aw_got && !s_q.bvalid) begin
         s_d.aw_got  = 1'b1;
         s_d.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !s_q.w_got && !s_q.bvalid) begin
         s_d.w_got  = 1'b1;
         s_d.w_data = s_axi_wdata;
         s_d.w_strb = s_axi_wstrb;
      end
      if (s_q.aw_got && s_q.w_got) begin
         s_d.aw_got  = 1'b0;
         s_d.w_got   = 1'b0;
         s_d.bvalid  = 1'b1;
         s_d.bresp   = TMCR_RESP_OKAY;
         unique case (s_q.aw_addr)
            TMCR_OFS_CFG:   s_d.cfg   = merge(s_q.cfg, s_q.w_data, s_q.w_strb, TMCR_CFG_WMASK);
            TMCR_OFS_AMODE: s_d.amode = merge(s_q.amode, s_q.w_data, s_q.w_strb,
                                              TMCR_MODE_WMASK);
            TMCR_OFS_BMODE: s_d.bmode = merge(s_q.bmode, s_q.w_data, s_q.w_strb,
                                              TMCR_MODE_WMASK);
            TMCR_OFS_CTL:   s_d.ctl   = merge(s_q.ctl, s_q.w_data, s_q.w_strb, TMCR_CTL_WMASK);
            TMCR_OFS_STAT:  s_d.bresp = TMCR_RESP_OKAY;
            default:        s_d.bresp = TMCR_RESP_SLVERR;
         endcase
      end
      if (s_q.bvalid && s_axi_bready) begin
         s_d.bvalid = 1'b0;
      end

      if (s_axi_arvalid && !s_q.rvalid) begin
         s_d.rvalid = 1'b1;
         s_d.rresp  = TMCR_RESP_OKAY;
         unique case (s_axi_araddr)
            TMCR_OFS_CFG:   s_d.rdata = s_q.cfg;
            TMCR_OFS_AMODE: s_d.rdata = s_q.amode;
            TMCR_OFS_BMODE: s_d.rdata = s_q.bmode;
            TMCR_OFS_CTL:   s_d.rdata = s_q.ctl; // R13
            TMCR_OFS_STAT:  s_d.rdata = {26'h0, halt_q, s_q.b_edge_time, s_q.b_mode_eff,
                                         s_q.b_capture_en, s_q.b_count_en};
            default: begin
               s_d.rdata = 32'h0000_0000;
               s_d.rresp = TMCR_RESP_SLVERR;
            end
         endcase
      end else if (s_q.rvalid && s_axi_rready) begin
         s_d.rvalid = 1'b0;
      end

      // split operation for codes 4-7, 32-bit for 0 and 1, 2 and 3 run nothing
      split = s_q.cfg[2]; // R12
      // 32-bit configurations ignore the TimerB mode register
      mode_sel = split ? s_q.bmode : s_q.amode; // R3 R4
      s_d.b_mode_eff  = mode_sel[TMCR_MODE_FIELD_LSB +: 2]; // R2
      s_d.b_edge_time = mode_sel[TMCR_MODE_CMR_BIT]; // R1
      s_d.b_edge_sel  = s_q.ctl[TMCR_CTL_B_EVT_LSB +: 2]; // R5
      // the freeze only bites while the debugger holds the core
      b_stall = s_q.ctl[TMCR_CTL_B_STL_BIT] && halt_q; // R6 R7
      b_en = s_q.ctl[TMCR_CTL_B_EN_BIT] && (split || s_q.cfg[2:0] == TMCR_CFG_32TIMER
             || s_q.cfg[2:0] == TMCR_CFG_32RTC); // R8 R12
      // capture mode with alternate select clear; alternate set means PWM counting
      s_d.b_capture_en = b_en && s_d.b_mode_eff == TMCR_TM_CAPTURE
                         && !mode_sel[TMCR_MODE_AMS_BIT]; // R8 R11
      s_d.b_count_en   = b_en && !b_stall && (s_d.b_mode_eff == TMCR_TM_ONESHOT
                         || s_d.b_mode_eff == TMCR_TM_PERIODIC
                         // reserved mode never runs, even with alternate set
                         || (mode_sel[TMCR_MODE_AMS_BIT] && s_d.b_mode_eff != TMCR_TM_RSVD));
      // R6 R8 R2
      s_d.a_pwm_out  = a_pwm_raw ^ s_q.ctl[TMCR_CTL_A_INV_BIT]; // R9
      s_d.a_adc_trig = a_trigger_raw && s_q.ctl[TMCR_CTL_A_OTE_BIT]; // R10
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_q       <= '0;
         s_q.cfg   <= TMCR_RESET_VAL;
         s_q.amode <= TMCR_RESET_VAL;
         s_q.bmode <= TMCR_RESET_VAL;
         s_q.ctl   <= TMCR_RESET_VAL;
      end else if (clk_en) begin
         s_q <= s_d;
      end
   end

   // write channels accept only while their holding slot is empty
   assign s_axi_awready      = !s_q.aw_got && !s_q.bvalid;
   assign s_axi_wready       = !s_q.w_got && !s_q.bvalid;
   assign s_axi_bvalid       = s_q.bvalid;
   assign s_axi_bresp        = s_q.bresp;
   assign s_axi_arready      = !s_q.rvalid;
   assign s_axi_rvalid       = s_q.rvalid;
   assign s_axi_rdata        = s_q.rdata;
   assign s_axi_rresp        = s_q.rresp;
   assign b_count_enable     = s_q.b_count_en;
   assign b_capture_enable   = s_q.b_capture_en;
   assign b_capture_submode  = s_q.b_edge_time;
   assign b_timer_mode_field = s_q.b_mode_eff;
   assign b_edge_select      = s_q.b_edge_sel;
   assign a_pwm_out          = s_q.a_pwm_out;
   assign a_adc_trigger      = s_q.a_adc_trig;
endmodule

// file: tmcr_regs_properties.sv
// assertions on the timer mode and control register ports
`timescale 1ns/10ps
module tmcr_regs_properties (
   input wire logic       aclk,
   input wire logic       aresetn,
   input wire logic       s_axi_awvalid,
   input wire logic       s_axi_awready,
   input wire logic       s_axi_wvalid,
   input wire logic       s_axi_wready,
   input wire logic       s_axi_bvalid,
   input wire logic       s_axi_arvalid,
   input wire logic       s_axi_arready,
   input wire logic       s_axi_rvalid,
   input wire logic       a_pwm_raw,
   input wire logic       a_trigger_raw,
   input wire logic       b_count_enable,
   input wire logic       b_capture_enable,
   input wire logic [1:0] b_timer_mode_field,
   input wire logic [1:0] b_edge_select,
   input wire logic       a_pwm_out,
   input wire logic       a_adc_trigger
);
   logic raw_q, bv_q, bv2_q;
   // edge select and pwm inversion only change one cycle after a write response rises
   wire  landed = bv_q & ~bv2_q;
   wire  inv    = a_pwm_out ^ raw_q;
   always_ff @(posedge aclk) begin
      raw_q <= a_pwm_raw;
      bv_q  <= s_axi_bvalid;
      bv2_q <= bv_q;
   end
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence wr_both;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   AST_WR_RESP: assert property (wr_both |-> ##[1:2] s_axi_bvalid)
      else $error("write response missing");
   AST_RD_RESP: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read response missing");
   AST_RD_BUSY: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while busy");
   AST_CAP_MODE: assert property (b_capture_enable |-> b_timer_mode_field == 2'h3)
      else $error("capture outside capture mode");
   AST_EXCL: assert property (!(b_count_enable && b_capture_enable))
      else $error("count and capture together");
   AST_RSVD_MODE: assert property (b_timer_mode_field == 2'h0 |-> !b_count_enable)
      else $error("reserved mode counts");
   AST_ADC_GATE: assert property (a_adc_trigger |-> $past(a_trigger_raw))
      else $error("trigger without raw trigger");
   AST_PWM_INV: assert property ($past(aresetn, 2) && !landed |-> $stable(inv))
      else $error("pwm inversion changed without write");
   AST_EDGE_HOLD: assert property ($changed(b_edge_select) |-> landed)
      else $error("edge select changed without write");
endmodule
bind tmcr_regs tmcr_regs_properties u_props (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
   .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
   .a_pwm_raw, .a_trigger_raw, .b_count_enable, .b_capture_enable, .b_timer_mode_field,
   .b_edge_select, .a_pwm_out, .a_adc_trigger);
